// *** tb/can_transmit_scheduler_test.sv ***
// Self-checking bench for the transmit scheduler
`timescale 1ns/1ps
module can_transmit_scheduler_test import cants_pkg::*;;
   logic core_clk, sys_rst, reg_wr, reg_rd, hold, rd_q, byte_q;
   logic [3:0] idx_q;
   logic [7:0] reg_addr;
   logic [15:0] reg_wdata, reg_rdata;
   logic [1:0] mode, tx_buffer;
   logic [3:0] tx_byte_index;
   logic [7:0] tx_byte;
   logic bus_idle, tx_start, tx_done, tx_lost_arb, tx_ack_error;
   logic tx_form_error, tx_bit_error, tx_busy, irq;
   logic [15:0] rq[$], sq[$], mem[14];
   int n_errors, check_count;
   cants_core dut_u (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .bus_idle, .tx_start, .tx_buffer, .tx_byte,
      .tx_byte_index, .tx_done, .tx_lost_arb, .tx_ack_error,
      .tx_form_error, .tx_bit_error, .tx_busy, .irq);
   cants_node_model far_u (.core_clk, .sys_rst, .tx_start, .hold, .mode,
      .bus_idle, .tx_done, .tx_lost_arb, .tx_ack_error, .tx_form_error,
      .tx_bit_error, .tx_byte_index);
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // ------
   // Tasks
   // ------
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task give_up;
      n_errors++;
      finish_test;
   endtask
   // Gap after each strobe keeps one drive per time step
   task wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      @(posedge core_clk);
   endtask
   task rd(input logic [7:0] a, input logic [15:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      rq.push_back(e);
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(posedge core_clk);
   endtask
   // Outcome pulses sampled mid-cycle where settled
   task wait_fail;
      int i;
      for (i = 0; i < 60; i++) begin
         @(negedge core_clk);
         if (tx_lost_arb || tx_ack_error || tx_form_error || tx_bit_error)
            break;
      end
      if (i == 60) give_up;
      @(posedge core_clk);
   endtask
   task drain;
      int i;
      for (i = 0; i < 300; i++) begin
         @(negedge core_clk);
         if (sq.size() == 0 && bus_idle && !tx_busy) break;
      end
      if (i == 300) give_up;
      @(posedge core_clk);
      hold <= 1'b1;
   endtask
   task round(input logic [15:0] c0, c1, c2, c3, o0, o1, o2);
      wr(CANTS_CTRL_BASE, c0);
      wr(CANTS_CTRL_BASE + 8'h01, c1);
      wr(CANTS_CTRL_BASE + 8'h02, c2);
      wr(CANTS_CTRL_BASE + 8'h02, c3);
      sq = '{o0, o1, o2};
      hold <= 1'b0;
      drain;
   endtask
   always @(posedge core_clk) begin
      if (rd_q) chk(reg_rdata, rq.pop_front());
      if (tx_start) chk({14'h0, tx_buffer}, sq.pop_front());
      // Byte fetched one cycle after its index
      if (byte_q) chk({8'h00, tx_byte}, {8'h00, mem[idx_q][7:0]});
      rd_q <= reg_rd;
      byte_q <= tx_busy && tx_buffer == 2'h1;
      idx_q <= tx_byte_index;
   end
   initial begin
      {n_errors, check_count} = '0;
      {sys_rst, hold} = 2'h3;
      {reg_wr, reg_rd, rd_q, byte_q, mode, reg_addr, reg_wdata} = '0;
      void'($urandom(77));
      repeat (2) @(posedge core_clk);
      sys_rst <= 1'b0;
      rd(CANTS_CTRL_BASE, 16'h0000);
      rd(CANTS_ERR_COUNT, 16'h0000);
      rd(8'h08, 16'h0000);
      for (int i = 0; i < CANTS_BUF_BYTES; i++) begin
         mem[i] = 16'($urandom);
         wr(CANTS_DATA_BASE + CANTS_DATA_STRIDE + 8'(i), mem[i]);
      end
      for (int i = 0; i < CANTS_BUF_BYTES; i++)
         rd(CANTS_DATA_BASE + CANTS_DATA_STRIDE + 8'(i), {8'h00, mem[i][7:0]});
      round(16'h000b, 16'h0008, 16'h0009, 16'h000b, 2, 0, 1);
      round(16'h0009, 16'h0008, 16'h0008, 16'h0008, 0, 2, 1);
      round(16'h000a, 16'h000b, 16'h000a, 16'h000a, 1, 2, 0);
      rd(CANTS_CTRL_BASE, 16'h0002);
      mode <= 2'h1;
      wr(CANTS_CTRL_BASE + 8'h01, 16'h008b);
      sq = '{16'h1, 16'h1};
      hold <= 1'b0;
      wait_fail;
      mode <= 2'h0;
      hold <= 1'b1;
      rd(CANTS_CTRL_BASE + 8'h01, 16'h00ab);
      chk({15'h0, irq}, 16'h0000);
      hold <= 1'b0;
      drain;
      chk({15'h0, irq}, 16'h0001);
      wr(CANTS_CTRL_BASE + 8'h01, 16'h0100);
      wr(CANTS_CTRL_BASE, 16'h0088);
      wr(CANTS_CTRL_BASE, 16'h0080);
      rd(CANTS_CTRL_BASE, 16'h00c0);
      wr(CANTS_CTRL_BASE, 16'h0088);
      rd(CANTS_CTRL_BASE, 16'h0088);
      wr(CANTS_CTRL_BASE + 8'h02, 16'h0008);
      wr(CANTS_MODULE_CTRL, 16'h1000);
      rd(CANTS_CTRL_BASE, 16'h00c0);
      rd(CANTS_CTRL_BASE + 8'h02, 16'h0040);
      rd(CANTS_MODULE_CTRL, 16'h0000);
      chk({15'h0, irq}, 16'h0000);
      mode <= 2'h2;
      wr(CANTS_CTRL_BASE + 8'h02, 16'h0008);
      for (int k = 0; k < 98; k++) sq.push_back(16'h2);
      hold <= 1'b0;
      for (int k = 0; k < 96; k++) wait_fail;
      rd(CANTS_IRQ_FLAGS, 16'h0000);
      wait_fail;
      mode <= 2'h0;
      drain;
      rd(CANTS_ERR_COUNT, 16'h0061);
      rd(CANTS_IRQ_FLAGS, 16'h0420);
      chk({15'h0, irq}, 16'h0001);
      finish_test;
   end
endmodule // can_transmit_scheduler_test

// *** tb/cants_core_sva.sv ***
// Port assertions for the transmit scheduler
`timescale 1ns/1ps
module cants_core_sva
   import cants_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_rd,
   input wire logic [15:0] reg_rdata,
   input wire logic bus_idle,
   input wire logic tx_start,
   input wire logic [1:0] tx_buffer,
   input wire logic tx_done,
   input wire logic tx_lost_arb,
   input wire logic tx_ack_error,
   input wire logic tx_form_error,
   input wire logic tx_bit_error,
   input wire logic tx_busy,
   input wire logic irq
);
   // ------
   // Shadow error count, outcome priority as the engine
   // ------
   logic [7:0] errs;
   logic fail_ev;
   assign fail_ev = tx_busy && !tx_done && !tx_lost_arb
      && (tx_ack_error || tx_form_error || tx_bit_error);
   always_ff @(posedge core_clk) begin
      if (sys_rst) errs <= 8'h00;
      else if (fail_ev && errs != 8'hff) errs <= errs + 8'h01;
   end
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   a_start_on_idle: assert property (tx_start |->
      $past(bus_idle) && !$past(tx_busy)) else $error("start on busy bus");
   a_busy_follows: assert property (tx_start |=> tx_busy)
      else $error("no busy after start");
   a_start_single: assert property (tx_start |=> !tx_start)
      else $error("start not a pulse");
   a_buffer_held: assert property (tx_busy && $past(tx_busy) |->
      $stable(tx_buffer)) else $error("buffer moved in frame");
   a_done_ends: assert property (tx_busy && tx_done |=> !tx_busy)
      else $error("busy after done");
   a_larb_quiet: assert property (
      tx_busy && tx_lost_arb && !tx_done && !irq |=> !irq)
      else $error("irq on lost arbitration");
   a_warn_irq: assert property (errs > 8'h60 |=> irq)
      else $error("no irq above warning count");
   a_count_read: assert property (
      reg_rd && reg_addr == CANTS_ERR_COUNT |=> reg_rdata[7:0] == $past(errs))
      else $error("error count wrong");
   c_start: cover property (tx_start);
   c_larb: cover property (tx_busy && tx_lost_arb);
   c_warn: cover property (errs == 8'h61);
endmodule // cants_core_sva
bind cants_core cants_core_sva sva_u (.core_clk, .sys_rst, .reg_addr,
   .reg_rd, .reg_rdata, .bus_idle, .tx_start, .tx_buffer, .tx_done,
   .tx_lost_arb, .tx_ack_error, .tx_form_error, .tx_bit_error, .tx_busy,
   .irq);

// *** tb/cants_node_model.sv ***
// Far-side bit engine and bus model
`timescale 1ns/1ps
module cants_node_model (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic tx_start,
   input wire logic hold,
   input wire logic [1:0] mode,
   output logic bus_idle,
   output logic tx_done,
   output logic tx_lost_arb,
   output logic tx_ack_error,
   output logic tx_form_error,
   output logic tx_bit_error,
   output logic [3:0] tx_byte_index
);
   logic [2:0] cnt;
   logic [1:0] kind;
   logic fin;
   assign fin = cnt == 3'h1;
   assign bus_idle = !hold && cnt == 3'h0;
   assign tx_done = fin && mode == 2'h0;
   assign tx_lost_arb = fin && mode == 2'h1;
   assign tx_ack_error = fin && mode == 2'h2 && kind == 2'h0;
   assign tx_form_error = fin && mode == 2'h2 && kind == 2'h1;
   assign tx_bit_error = fin && mode == 2'h2 && kind == 2'h2;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cnt <= 3'h0;
         kind <= 2'h0;
         tx_byte_index <= 4'h0;
      end else begin
         // Short frame keeps the error run cheap
         if (tx_start) cnt <= 3'h5;
         else if (cnt != 3'h0) cnt <= cnt - 3'h1;
         if (fin && mode == 2'h2) kind <= (kind == 2'h2) ? 2'h0 : kind + 2'h1;
         tx_byte_index <= (tx_byte_index == 4'hd) ? 4'h0 : tx_byte_index + 4'h1;
      end
   end
endmodule // cants_node_model

// *** verilog/cants_core.sv ***
// CAN transmit scheduler: buffers, priority pick, flags, error count
// Functional notes
// - Three buffers of 14 bytes: 8 payload, 5 identifier bytes.
// - Priority field bits 1:0; value 11 is highest.
// - Priority 10 or 01 is intermediate.
// - Priority 00 is lowest.
// - Priority changes before frame start are honoured.
// - Setting request clears aborted, lost-arbitration and error flags.
// - When bus free, send highest-priority pending buffer.
// - Success clears request; flag interrupt if enabled.
// - Failure sets an error flag and keeps request set.
// - Error during attempt sets error flag; may interrupt.
// - Lost arbitration sets its flag, no interrupt.
// - Abort-all bit 12 requests abort of every pending buffer.
// - Abort only if not started, or after loss or error.
// - Abort sets aborted flag, not the interrupt flag.
// - Ack, form and bit errors each add one to error count; code adds one per failed attempt however many of them are set together.
// - Count above 96 sets error flag, warning flag, interrupt.
//
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/1ps
module cants_core
   import cants_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic bus_idle,
   output logic tx_start,
   output logic [1:0] tx_buffer,
   output logic [7:0] tx_byte,
   input wire logic [3:0] tx_byte_index,
   input wire logic tx_done,
   input wire logic tx_lost_arb,
   input wire logic tx_ack_error,
   input wire logic tx_form_error,
   input wire logic tx_bit_error,
   output logic tx_busy,
   output logic irq
);
   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      logic [CANTS_NBUF-1:0][1:0] pri;
      logic [CANTS_NBUF-1:0] req;
      logic [CANTS_NBUF-1:0] err;
      logic [CANTS_NBUF-1:0] larb;
      logic [CANTS_NBUF-1:0] abt;
      logic [CANTS_NBUF-1:0] ie;
      logic [CANTS_NBUF-1:0] iflag;
      logic abort_all_request;
      logic error_irq_flag;
      logic tx_warning_flag;
      logic [7:0] errcnt;
      cants_state_type state;
      logic [1:0] cur;
      logic start;
      logic [15:0] rdata;
      logic [7:0] txb;
   } cants_regs_type;

   cants_regs_type r;
   cants_regs_type next_r;
   logic [7:0] mem [CANTS_NBUF][CANTS_BUF_BYTES];
   logic found;
   logic [1:0] winner;
   logic any_err;

   function automatic logic [7:0] ctrl_addr(input logic [1:0] b);
      return CANTS_CTRL_BASE + 8'(b);
   endfunction

   function automatic logic data_hit(input logic [7:0] a,
                                     input logic [1:0] b);
      logic [7:0] base;
      base = CANTS_DATA_BASE + 8'(b) * CANTS_DATA_STRIDE;
      return a >= base && a < base + 8'(CANTS_BUF_BYTES);
   endfunction

   // pick sees live request and priority
   cants_pick u_pick (
      .pending(r.req),
      .prio(r.pri),
      .found(found),
      .winner(winner)
   );

   assign any_err = tx_ack_error | tx_form_error | tx_bit_error;
   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      next_r = r;
      next_r.start = 1'b0;
      next_r.rdata = 16'h0000;
      next_r.txb = mem[r.cur][tx_byte_index];
      // Register writes first; hardware events below win over them
      if (reg_wr) begin
         for (int b = 0; b < CANTS_NBUF; b++) begin
            if (reg_addr == ctrl_addr(2'(b))) begin
               next_r.pri[b] = reg_wdata[CANTS_PRI_LSB +: 2];
               next_r.ie[b] = reg_wdata[CANTS_IE_BIT];
               // Flag write of one clears it
               if (reg_wdata[CANTS_IF_BIT])
                  next_r.iflag[b] = 1'b0;
               if (!reg_wdata[CANTS_REQ_BIT] && r.req[b] &&
                   !(r.state == CANTS_SEND && r.cur == 2'(b))) begin
                  next_r.req[b] = 1'b0;
                  next_r.abt[b] = 1'b1;
               end
               if (reg_wdata[CANTS_REQ_BIT] && !r.req[b]) begin
                  next_r.req[b] = 1'b1;
                  next_r.abt[b] = 1'b0;
                  next_r.larb[b] = 1'b0;
                  next_r.err[b] = 1'b0;
               end
            end
         end
         if (reg_addr == CANTS_MODULE_CTRL && reg_wdata[CANTS_ABORT_ALL_REQUEST_BIT])
            next_r.abort_all_request = 1'b1;
         if (reg_addr == CANTS_IRQ_FLAGS) begin
            if (reg_wdata[CANTS_ERROR_IRQ_FLAG_BIT])
               next_r.error_irq_flag = 1'b0;
            if (reg_wdata[CANTS_TX_WARNING_FLAG_BIT])
               next_r.tx_warning_flag = 1'b0;
         end
      end
      if (r.abort_all_request) begin
         for (int b = 0; b < CANTS_NBUF; b++) begin
            if (r.req[b] && !(r.state == CANTS_SEND && r.cur == 2'(b))) begin
               next_r.req[b] = 1'b0;
               next_r.abt[b] = 1'b1;
            end
         end
         if (r.state == CANTS_IDLE)
            next_r.abort_all_request = 1'b0;
      end
      unique case (r.state)
         CANTS_IDLE: begin
            if (bus_idle && found && !r.abort_all_request) begin
               next_r.state = CANTS_SEND;
               next_r.cur = winner;
               next_r.start = 1'b1;
            end
         end
         CANTS_SEND: begin
            if (tx_done) begin
               next_r.req[r.cur] = 1'b0;
               if (r.ie[r.cur])
                  next_r.iflag[r.cur] = 1'b1;
               next_r.state = CANTS_IDLE;
            end else if (tx_lost_arb) begin
               next_r.larb[r.cur] = 1'b1;
               next_r.state = CANTS_IDLE;
            end else if (any_err) begin
               next_r.err[r.cur] = 1'b1;
               if (r.ie[r.cur])
                  next_r.iflag[r.cur] = 1'b1;
               next_r.state = CANTS_IDLE;
            end
         end
      endcase
      if (r.state == CANTS_SEND && any_err && !tx_done && !tx_lost_arb &&
          r.errcnt != 8'hff)
         next_r.errcnt = r.errcnt + 8'h01;
      if (r.errcnt > CANTS_WARN_LIMIT) begin
         next_r.error_irq_flag = 1'b1;
         next_r.tx_warning_flag = 1'b1;
      end
      if (reg_rd) begin
         for (int b = 0; b < CANTS_NBUF; b++) begin
            if (reg_addr == ctrl_addr(2'(b)))
               next_r.rdata = {7'h00, r.iflag[b], r.ie[b], r.abt[b],
                               r.larb[b], r.err[b], r.req[b], 1'b0,
                               r.pri[b]};
            for (int i = 0; i < CANTS_BUF_BYTES; i++)
               if (reg_addr == CANTS_DATA_BASE +
                   8'(b) * CANTS_DATA_STRIDE + 8'(i))
                  next_r.rdata = {8'h00, mem[b][i]};
         end
         if (reg_addr == CANTS_MODULE_CTRL)
            next_r.rdata = 16'(r.abort_all_request) << CANTS_ABORT_ALL_REQUEST_BIT;
         if (reg_addr == CANTS_IRQ_FLAGS)
            next_r.rdata = (16'(r.error_irq_flag) << CANTS_ERROR_IRQ_FLAG_BIT) |
                           (16'(r.tx_warning_flag) << CANTS_TX_WARNING_FLAG_BIT);
         if (reg_addr == CANTS_ERR_COUNT)
            next_r.rdata = {8'h00, r.errcnt};
      end
   end
   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         r <= '0;
         r.state <= CANTS_IDLE;
         r.errcnt <= CANTS_ERRCNT_RESET;
         for (int b = 0; b < CANTS_NBUF; b++)
            r.pri[b] <= CANTS_PRI_RESET;
      end else begin
         r <= next_r;
      end
   end

   // Buffer bytes are not reset; software loads before requesting
   always_ff @(posedge core_clk) begin
      for (int b = 0; b < CANTS_NBUF; b++)
         for (int i = 0; i < CANTS_BUF_BYTES; i++)
            if (reg_wr && reg_addr == CANTS_DATA_BASE +
                8'(b) * CANTS_DATA_STRIDE + 8'(i) && data_hit(reg_addr, 2'(b)))
               mem[b][i] <= reg_wdata[7:0];
   end
   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign reg_rdata = r.rdata;
   assign tx_start = r.start;
   assign tx_buffer = r.cur;
   assign tx_byte = r.txb;
   assign tx_busy = r.state == CANTS_SEND;
   // error flag or buffer flag drives interrupt line
   assign irq = r.error_irq_flag | (|r.iflag);
endmodule // cants_core

// *** verilog/cants_pick.sv ***
// Priority picker for the pending transmit buffers
`timescale 1ns/1ps
module cants_pick
   import cants_pkg::*;
(
   input wire logic [CANTS_NBUF-1:0] pending,
   input wire logic [2*CANTS_NBUF-1:0] prio,
   output logic found,
   output logic [1:0] winner
);
   // ------------------------------------------------------------
   // Selection
   // ------------------------------------------------------------
   always_comb begin
      logic [1:0] best;
      best = 2'h0;
      found = 1'b0;
      winner = 2'h0;
      for (int i = 0; i < CANTS_NBUF; i++) begin
         if (pending[i] && (!found || prio[2*i +: 2] >= best)) begin
            found = 1'b1;
            best = prio[2*i +: 2];
            winner = 2'(i);
         end
      end
   end
endmodule // cants_pick

// *** verilog/cants_pkg.sv ***
// Constants and types for the CAN transmit scheduler
package cants_pkg;
   // ------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------
   localparam int CANTS_NBUF = 3;
   localparam int CANTS_BUF_BYTES = 14;
   localparam int CANTS_PAYLOAD_BYTES = 8;
   localparam int CANTS_ID_BYTES = 5;
   // ------------------------------------------------------------
   // Register offsets (word addresses on the 8-bit address port)
   // ------------------------------------------------------------
   localparam logic [7:0] CANTS_CTRL_BASE = 8'h00;
   localparam logic [7:0] CANTS_MODULE_CTRL = 8'h04;
   localparam logic [7:0] CANTS_IRQ_FLAGS = 8'h05;
   localparam logic [7:0] CANTS_ERR_COUNT = 8'h06;
   localparam logic [7:0] CANTS_DATA_BASE = 8'h10;
   localparam logic [7:0] CANTS_DATA_STRIDE = 8'h10;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int CANTS_PRI_LSB = 0;
   localparam int CANTS_REQ_BIT = 3;
   localparam int CANTS_ERR_BIT = 4;
   localparam int CANTS_LARB_BIT = 5;
   localparam int CANTS_ABT_BIT = 6;
   localparam int CANTS_IE_BIT = 7;
   localparam int CANTS_IF_BIT = 8;
   localparam int CANTS_ABORT_ALL_REQUEST_BIT = 12;
   localparam int CANTS_ERROR_IRQ_FLAG_BIT = 5;
   localparam int CANTS_TX_WARNING_FLAG_BIT = 10;
   // ------------------------------------------------------------
   // Reset values and limits
   // ------------------------------------------------------------
   localparam logic [7:0] CANTS_WARN_LIMIT = 8'h60;
   localparam logic [7:0] CANTS_ERRCNT_RESET = 8'h00;
   localparam logic [1:0] CANTS_PRI_RESET = 2'h0;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      CANTS_RES_OK,
      CANTS_RES_LARB,
      CANTS_RES_ERR
   } cants_result_type;
   typedef enum {
      CANTS_IDLE,
      CANTS_SEND
   } cants_state_type;
endpackage
